// >>> core/aib_top.sv
/*
 * Aux status and mask, interrupt enables,
 * pending index and breakpoint slots.
 * Assumes one clock, synchronous reset;
 * read data one cycle after the strobe.
 * Events are pulses, supply inputs levels.
 * Registers reached as core SFRs.
 */
`timescale 1ns/10ps

// Behaviour
// R1: Status reads active-and-unmasked sources only
// R2: Priority by bit, bit 0 highest
// R3: Reading one-hertz tick register clears bit 7
// R4: Reading accumulate low byte clears bit 6
// R5: Conversion low-byte read clears; blocks overwrite
// R6: Reading kilohertz tick register clears bit 4
// R7: Writing serial data clears bit 3
// R8: Reading serial data clears bit 2
// R9: Analog low flag follows detector level
// R10: Bit 0 is digital low or breakpoint
// R11: Global gate masks enable register only
// R12: Enable bits 5,3,1 gate timer overflows
// R13: Enable bits 6,4 gate serial ports
// R14: Enable bits 2,0 gate external pins
// R15: Control write loads selected breakpoint slot
// R16: Control bit 7 reads any breakpoint hit
// R17: Writing 1 to bit 7 clears selected slot hit
// R18: Control bit 1 picks compared address space
// R19: Control bit 0 arms selected slot
// R20: Compare address built from high and low
// R21: Mask write enables; mask read shows raw
// R22: Shared vector, index of highest pending source
// R23: Flags and clears act on system clock
module aib_top
#(
    parameter int NUM_SLOTS = 2,
    parameter int SEL_W     = 1
)
(
    input  wire logic                  clock,
    input  wire logic                  reset_n,
    input  wire aib_pkg::aib_sfr_req_t sfrReq,
    input  wire aib_pkg::aib_aux_evt_t auxEvt,
    input  wire logic                  analogSupplyLow,
    input  wire logic                  digitalSupplyLow,
    input  wire aib_pkg::aib_std_src_t stdSrc,
    input  wire logic [SEL_W-1:0]      brkSlotSelect,
    input  wire logic [15:0]           dataAddr,
    input  wire logic                  dataAddrValid,
    input  wire logic [15:0]           progAddr,
    input  wire logic                  progAddrValid,
    output logic [7:0]                 sfrRdata,
    output logic                       sfrHit,
    output logic                       auxIrqReq,
    output logic [15:0]                auxIrqVector,
    output logic [3:0]                 auxPendingIndex,
    output logic                       convHoldOff,
    output logic [6:0]                 stdIrqReq,
    output logic                       brkHitAny
);

    // Register bus decode
    logic rdSerial;
    logic wrSerial;
    logic wrMask;
    logic wrEnable;
    logic wrControl;
    logic wrLo;
    logic wrHi;

    assign rdSerial  = sfrReq.rd && (sfrReq.addr == aib_pkg::ADDR_SERIAL_DATA);
    assign wrSerial  = sfrReq.wr && (sfrReq.addr == aib_pkg::ADDR_SERIAL_DATA);
    assign wrMask    = sfrReq.wr && (sfrReq.addr == aib_pkg::ADDR_AUX_MASK);
    assign wrEnable  = sfrReq.wr && (sfrReq.addr == aib_pkg::ADDR_IRQ_ENABLE);
    assign wrControl = sfrReq.wr && (sfrReq.addr == aib_pkg::ADDR_BRK_CONTROL);
    assign wrLo      = sfrReq.wr && (sfrReq.addr == aib_pkg::ADDR_BRK_LO);
    assign wrHi      = sfrReq.wr && (sfrReq.addr == aib_pkg::ADDR_BRK_HI);

    // Software-visible registers
    logic [7:0] auxMask_reg;
    logic [7:0] irqEnable_reg;
    logic [7:0] brkAddrLo_reg;
    logic [7:0] brkAddrHi_reg;

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            auxMask_reg <= aib_pkg::REG_RESET;
        else if (wrMask)
            auxMask_reg <= sfrReq.wdata; // see R21
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            irqEnable_reg <= aib_pkg::REG_RESET;
        else if (wrEnable)
            irqEnable_reg <= sfrReq.wdata;
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            brkAddrLo_reg <= aib_pkg::REG_RESET;
            brkAddrHi_reg <= aib_pkg::REG_RESET;
        end
        else
        begin
            if (wrLo)
                brkAddrLo_reg <= sfrReq.wdata;
            if (wrHi)
                brkAddrHi_reg <= sfrReq.wdata;
        end
    end

    // Breakpoint slots
    logic [NUM_SLOTS-1:0]  slotHit;
    aib_pkg::aib_brk_cfg_t slotCfg [NUM_SLOTS];
    aib_pkg::aib_brk_cfg_t cfgLoad;
    logic                  anyHit;

    always_comb
    begin
        cfgLoad.arm   = sfrReq.wdata[aib_pkg::BRK_BIT_ARM]; // see R19
        cfgLoad.space = aib_pkg::aib_space_t'(sfrReq.wdata[aib_pkg::BRK_BIT_SPACE]); // see R18
        cfgLoad.addr  = {brkAddrHi_reg, brkAddrLo_reg}; // see R20
    end

    genvar s;
    generate
        for (s = 0; s < NUM_SLOTS; s++)
        begin : gSlot
            logic selected;

            assign selected = (brkSlotSelect == SEL_W'(s));

            aib_brk_slot uSlot
            (
                .clock         (clock),
                .reset_n       (reset_n),
                .load          (wrControl && selected), // see R15
                .cfgIn         (cfgLoad),
                .clearHit      (wrControl && selected && sfrReq.wdata[aib_pkg::BRK_BIT_HIT]), // see R17
                .dataAddr      (dataAddr),
                .dataAddrValid (dataAddrValid),
                .progAddr      (progAddr),
                .progAddrValid (progAddrValid),
                .cfg           (slotCfg[s]),
                .hit           (slotHit[s])
            );
        end
    endgenerate

    assign anyHit = |slotHit; // see R16

    // Selected slot view for control readback
    aib_pkg::aib_brk_cfg_t selCfg;

    always_comb
    begin
        selCfg = '{arm: 1'b0, space: aib_pkg::AIB_SPACE_DATA, addr: aib_pkg::ADDR16_RESET};
        for (int i = 0; i < NUM_SLOTS; i++)
        begin
            if (brkSlotSelect == SEL_W'(i))
                selCfg = slotCfg[i];
        end
    end

    // Raw auxiliary sources, before masking
    logic oneHz_reg;
    logic accum_reg;
    logic conv_reg;
    logic kilohertz_reg;
    logic serialTx_reg;
    logic serialRx_reg;
    logic [7:0] auxRaw;
    logic [7:0] auxStatus;

    // In each flag the new event wins over a clearing access
    always_ff @(posedge clock)
    begin
        if (!reset_n)
            oneHz_reg <= 1'b0;
        else if (auxEvt.oneHzTick)
            oneHz_reg <= 1'b1;
        else if (auxEvt.oneHzRegRead)
            oneHz_reg <= 1'b0; // see R3
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            accum_reg <= 1'b0;
        else if (auxEvt.accumulateDone)
            accum_reg <= 1'b1;
        else if (auxEvt.accumLsbRead)
            accum_reg <= 1'b0; // see R4
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            conv_reg <= 1'b0;
        else if (auxEvt.conversionDone)
            conv_reg <= 1'b1;
        else if (auxEvt.convLsbRead)
            conv_reg <= 1'b0; // see R5
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            kilohertz_reg <= 1'b0;
        else if (auxEvt.kilohertzTick)
            kilohertz_reg <= 1'b1;
        else if (auxEvt.kilohertzRegRead)
            kilohertz_reg <= 1'b0; // see R6
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            serialTx_reg <= 1'b0;
        else if (auxEvt.serialTxDone)
            serialTx_reg <= 1'b1;
        else if (wrSerial)
            serialTx_reg <= 1'b0; // see R7
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            serialRx_reg <= 1'b0;
        else if (auxEvt.serialRxDone)
            serialRx_reg <= 1'b1;
        else if (rdSerial)
            serialRx_reg <= 1'b0; // see R8
    end

    always_comb
    begin
        auxRaw                              = aib_pkg::REG_RESET;
        auxRaw[aib_pkg::AUX_BIT_ONE_HZ]     = oneHz_reg;
        auxRaw[aib_pkg::AUX_BIT_ACCUM]      = accum_reg;
        auxRaw[aib_pkg::AUX_BIT_CONV]       = conv_reg;
        auxRaw[aib_pkg::AUX_BIT_KILOHERTZ]  = kilohertz_reg;
        auxRaw[aib_pkg::AUX_BIT_SERIAL_TX]  = serialTx_reg;
        auxRaw[aib_pkg::AUX_BIT_SERIAL_RX]  = serialRx_reg;
        auxRaw[aib_pkg::AUX_BIT_ANALOG_LOW] = analogSupplyLow; // see R9
        auxRaw[aib_pkg::AUX_BIT_DIGITAL]    = digitalSupplyLow | anyHit; // see R10
    end

    assign auxStatus = auxRaw & auxMask_reg; // see R1

    logic [3:0] pendIndex;

    aib_aux_prio uPrio
    (
        .status (auxStatus),
        .index  (pendIndex)
    );

    // Standard interrupt gating
    logic [6:0] stdRaw;
    logic [6:0] stdNext;

    always_comb
    begin
        stdRaw                        = 7'h00;
        stdRaw[aib_pkg::IE_BIT_EXT0]   = stdSrc.extIrqPin0; // see R14
        stdRaw[aib_pkg::IE_BIT_TIMER0] = stdSrc.timer0Overflow; // see R12
        stdRaw[aib_pkg::IE_BIT_EXT1]   = stdSrc.extIrqPin1; // see R14
        stdRaw[aib_pkg::IE_BIT_TIMER1] = stdSrc.timer1Overflow; // see R12
        stdRaw[aib_pkg::IE_BIT_UART0]  = stdSrc.uart0Rx | stdSrc.uart0Tx; // see R13
        stdRaw[aib_pkg::IE_BIT_TIMER2] = stdSrc.timer2Overflow; // see R12
        stdRaw[aib_pkg::IE_BIT_UART1]  = stdSrc.uart1Rx | stdSrc.uart1Tx; // see R13
    end

    assign stdNext = stdRaw & irqEnable_reg[6:0] & {7{irqEnable_reg[aib_pkg::IE_BIT_GLOBAL]}}; // see R11

    // Read data mux
    logic [7:0] readNext;
    logic       hitNext;

    always_comb
    begin
        readNext = aib_pkg::REG_RESET;
        hitNext  = 1'b1;
        case (sfrReq.addr)
            aib_pkg::ADDR_PEND_INDEX:  readNext = {4'h0, pendIndex}; // see R22
            aib_pkg::ADDR_AUX_MASK:    readNext = auxRaw; // see R21
            aib_pkg::ADDR_AUX_STATUS:  readNext = auxStatus; // see R1
            aib_pkg::ADDR_IRQ_ENABLE:  readNext = irqEnable_reg;
            aib_pkg::ADDR_BRK_CONTROL: readNext = {anyHit, 5'h00, selCfg.space, selCfg.arm}; // see R16
            aib_pkg::ADDR_BRK_LO:      readNext = brkAddrLo_reg;
            aib_pkg::ADDR_BRK_HI:      readNext = brkAddrHi_reg;
            default:                   hitNext  = 1'b0;
        endcase
    end

    // Registered answer to a read; zero otherwise so it can be ORed
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            sfrRdata <= aib_pkg::REG_RESET;
            sfrHit   <= 1'b0;
        end
        else if (sfrReq.rd)
        begin
            sfrRdata <= readNext;
            sfrHit   <= hitNext;
        end
        else
        begin
            sfrRdata <= aib_pkg::REG_RESET;
            sfrHit   <= 1'b0;
        end
    end

    // Interrupt outputs
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            auxIrqReq       <= 1'b0;
            auxPendingIndex <= aib_pkg::PEND_INDEX_NONE;
            auxIrqVector    <= aib_pkg::ADDR16_RESET;
        end
        else
        begin
            auxIrqReq       <= |auxStatus;
            auxPendingIndex <= pendIndex; // see R22
            auxIrqVector    <= aib_pkg::AUX_VECTOR; // see R22
        end
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            stdIrqReq <= 7'h00;
        else
            stdIrqReq <= stdNext; // see R23
    end

    // Conversion holdoff follows the raw ready flag, masked or not
    always_ff @(posedge clock)
    begin
        if (!reset_n)
            convHoldOff <= 1'b0;
        else
            convHoldOff <= conv_reg || auxEvt.conversionDone; // see R5
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            brkHitAny <= 1'b0;
        else
            brkHitAny <= anyHit;
    end

endmodule

// >>> core/aib_pkg.sv
/*
 * Constants, types and carriers of the unit.
 * Assumes one SFR request struct on the system clock.
 */
package aib_pkg;

    // Register addresses on the special function register bus
    localparam logic [7:0] ADDR_SERIAL_DATA = 8'h9B;
    localparam logic [7:0] ADDR_PEND_INDEX  = 8'hA5;
    localparam logic [7:0] ADDR_AUX_MASK    = 8'hA6;
    localparam logic [7:0] ADDR_AUX_STATUS  = 8'hA7;
    localparam logic [7:0] ADDR_IRQ_ENABLE  = 8'hA8;
    localparam logic [7:0] ADDR_BRK_CONTROL = 8'hA9;
    localparam logic [7:0] ADDR_BRK_LO      = 8'hAA;
    localparam logic [7:0] ADDR_BRK_HI      = 8'hAB;

    // Reset values
    localparam logic [7:0]  REG_RESET        = 8'h00;
    localparam logic [15:0] ADDR16_RESET     = 16'h0000;
    localparam logic [3:0]  PEND_INDEX_NONE  = 4'h0;

    // Auxiliary status and mask bit positions, bit 0 highest priority
    localparam int AUX_BIT_ONE_HZ     = 7;
    localparam int AUX_BIT_ACCUM      = 6;
    localparam int AUX_BIT_CONV       = 5;
    localparam int AUX_BIT_KILOHERTZ  = 4;
    localparam int AUX_BIT_SERIAL_TX  = 3;
    localparam int AUX_BIT_SERIAL_RX  = 2;
    localparam int AUX_BIT_ANALOG_LOW = 1;
    localparam int AUX_BIT_DIGITAL    = 0;

    // Enable register bit positions
    localparam int IE_BIT_GLOBAL = 7;
    localparam int IE_BIT_UART1  = 6;
    localparam int IE_BIT_TIMER2 = 5;
    localparam int IE_BIT_UART0  = 4;
    localparam int IE_BIT_TIMER1 = 3;
    localparam int IE_BIT_EXT1   = 2;
    localparam int IE_BIT_TIMER0 = 1;
    localparam int IE_BIT_EXT0   = 0;

    // Breakpoint control bit positions
    localparam int BRK_BIT_HIT   = 7;
    localparam int BRK_BIT_SPACE = 1;
    localparam int BRK_BIT_ARM   = 0;

    // Shared vector of all auxiliary interrupts
    localparam logic [15:0] AUX_VECTOR = 16'h0033;

    typedef enum logic
    {
        AIB_SPACE_DATA = 1'b0,
        AIB_SPACE_PROG = 1'b1
    } aib_space_t;

    typedef struct packed
    {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } aib_sfr_req_t;

    typedef struct packed
    {
        logic oneHzTick;
        logic accumulateDone;
        logic conversionDone;
        logic kilohertzTick;
        logic serialTxDone;
        logic serialRxDone;
        logic oneHzRegRead;
        logic accumLsbRead;
        logic convLsbRead;
        logic kilohertzRegRead;
    } aib_aux_evt_t;

    typedef struct packed
    {
        logic uart1Rx;
        logic uart1Tx;
        logic timer2Overflow;
        logic uart0Rx;
        logic uart0Tx;
        logic timer1Overflow;
        logic extIrqPin1;
        logic timer0Overflow;
        logic extIrqPin0;
    } aib_std_src_t;

    typedef struct packed
    {
        logic        arm;
        aib_space_t  space;
        logic [15:0] addr;
    } aib_brk_cfg_t;

endpackage

// >>> core/aib_brk_slot.sv
/*
 * One breakpoint slot: config and sticky hit.
 * Assumes one-cycle address valid strobes.
 */
`timescale 1ns/10ps

module aib_brk_slot
(
    input  wire logic                 clock,
    input  wire logic                 reset_n,
    input  wire logic                 load,
    input  wire aib_pkg::aib_brk_cfg_t cfgIn,
    input  wire logic                 clearHit,
    input  wire logic [15:0]          dataAddr,
    input  wire logic                 dataAddrValid,
    input  wire logic [15:0]          progAddr,
    input  wire logic                 progAddrValid,
    output aib_pkg::aib_brk_cfg_t     cfg,
    output logic                      hit
);

    aib_pkg::aib_brk_cfg_t cfg_reg;
    logic                  hit_reg;
    logic                  match;

    always_comb
    begin
        if (cfg_reg.space == aib_pkg::AIB_SPACE_PROG)
            match = progAddrValid && (progAddr == cfg_reg.addr); // see R18
        else
            match = dataAddrValid && (dataAddr == cfg_reg.addr); // see R18
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            cfg_reg <= '{arm: 1'b0, space: aib_pkg::AIB_SPACE_DATA, addr: aib_pkg::ADDR16_RESET};
        else if (load)
            cfg_reg <= cfgIn; // see R15
    end

    // A new match wins over a clear in the same cycle
    always_ff @(posedge clock)
    begin
        if (!reset_n)
            hit_reg <= 1'b0;
        else if (cfg_reg.arm && match) // see R19
            hit_reg <= 1'b1;
        else if (clearHit)
            hit_reg <= 1'b0; // see R17
    end

    assign cfg = cfg_reg;
    assign hit = hit_reg;

endmodule

// >>> core/aib_aux_prio.sv
/*
 * Priority encoder: bit 0 gives 1, bit 7 gives 8.
 * Assumes masked flags; combinational.
 */
`timescale 1ns/10ps

module aib_aux_prio
(
    input  wire logic [7:0] status,
    output logic [3:0]      index
);

    always_comb
    begin
        index = aib_pkg::PEND_INDEX_NONE;
        for (int i = 7; i >= 0; i--)
        begin
            if (status[i])
                index = 4'(i + 1); // see R2
        end
    end

endmodule

// >>> tb/aib_top_props.sv
/*
 * Assertion checker for the aux interrupt and breakpoint unit.
 * Sees only the top ports; bound to the top module from the bench.
 */
`timescale 1ns/10ps

module aib_top_props
#(
    parameter int NUM_SLOTS = 2,
    parameter int SEL_W     = 1
)
(
    input wire logic                  clock,
    input wire logic                  reset_n,
    input wire aib_pkg::aib_sfr_req_t sfrReq,
    input wire aib_pkg::aib_aux_evt_t auxEvt,
    input wire logic                  analogSupplyLow,
    input wire logic                  digitalSupplyLow,
    input wire aib_pkg::aib_std_src_t stdSrc,
    input wire logic [SEL_W-1:0]      brkSlotSelect,
    input wire logic [15:0]           dataAddr,
    input wire logic                  dataAddrValid,
    input wire logic [15:0]           progAddr,
    input wire logic                  progAddrValid,
    input wire logic [7:0]            sfrRdata,
    input wire logic                  sfrHit,
    input wire logic                  auxIrqReq,
    input wire logic [15:0]           auxIrqVector,
    input wire logic [3:0]            auxPendingIndex,
    input wire logic                  convHoldOff,
    input wire logic [6:0]            stdIrqReq,
    input wire logic                  brkHitAny
);
    logic [7:0] ieSh;
    logic [7:0] maskSh;
    logic       rdMapped;
    logic [6:0] stdExp;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    assign rdMapped = sfrReq.rd && sfrReq.addr >= 8'hA5 && sfrReq.addr <= 8'hAB;
    assign stdExp = {stdSrc.uart1Rx | stdSrc.uart1Tx, stdSrc.timer2Overflow, stdSrc.uart0Rx | stdSrc.uart0Tx,
                     stdSrc.timer1Overflow, stdSrc.extIrqPin1, stdSrc.timer0Overflow, stdSrc.extIrqPin0}
                    & ieSh[6:0] & {7{ieSh[7]}};

    // Shadow of the enable register
    always_ff @(posedge clock)
    begin
        if (!reset_n)
            ieSh <= 8'h00;
        else if (sfrReq.wr && sfrReq.addr == 8'hA8)
            ieSh <= sfrReq.wdata;
    end

    // Shadow of the aux mask register
    always_ff @(posedge clock)
    begin
        if (!reset_n)
            maskSh <= 8'h00;
        else if (sfrReq.wr && sfrReq.addr == 8'hA6)
            maskSh <= sfrReq.wdata;
    end

    a_read_hit_next: assert property (rdMapped |=> sfrHit)
        else $error("no hit after mapped read");
    a_idle_bus_quiet: assert property (!rdMapped |=> !sfrHit && sfrRdata == 8'h00)
        else $error("read data without mapped read");
    a_vector_fixed: assert property ($past(reset_n) |-> auxIrqVector == 16'h0033)
        else $error("aux vector wrong");
    a_req_index_pair: assert property (auxIrqReq == (auxPendingIndex != 4'h0))
        else $error("request and index disagree");
    a_std_gated: assert property (stdIrqReq == $past(stdExp))
        else $error("standard request gating wrong");
    a_masked_quiet: assert property ((maskSh == 8'h00)[*3] |-> !auxIrqReq)
        else $error("aux request while all masked");
    a_analog_index: assert property ((analogSupplyLow && maskSh[1] && !maskSh[0])[*3] |-> auxPendingIndex == 4'h2)
        else $error("analog low not pending");
    a_digital_index: assert property ((digitalSupplyLow && maskSh[0])[*3] |-> auxPendingIndex == 4'h1)
        else $error("digital low not top pending");
    a_brk_aux_req: assert property ((brkHitAny && maskSh[0])[*2] |-> auxIrqReq)
        else $error("breakpoint hit without aux request");
    a_conv_hold_set: assert property (auxEvt.conversionDone |-> ##[0:2] convHoldOff)
        else $error("conversion hold missing");
    a_conv_hold_free: assert property ((auxEvt.convLsbRead && !auxEvt.conversionDone)
        ##1 (!auxEvt.conversionDone)[*2] |-> !convHoldOff)
        else $error("conversion hold not released");

    c_brk_hit: cover property ($rose(brkHitAny));
    c_many_pending: cover property (auxPendingIndex == 4'h3 && auxIrqReq);
    c_std_all: cover property (stdIrqReq == 7'h7F);
endmodule

// >>> tb/aib_core_model.sv
/*
 * Processor core model: makes special function register accesses.
 * Assumes the bench calls its tasks; requests change at the falling edge.
 */
`timescale 1ns/10ps

module aib_core_model
(
    input  wire logic              clock,
    output aib_pkg::aib_sfr_req_t  sfrReq,
    input  wire logic [7:0]        sfrRdata
);
    initial sfrReq = '{addr: 8'h00, wdata: 8'h00, wr: 1'b0, rd: 1'b0};

    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        sfrReq = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(negedge clock);
        sfrReq = '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask

    // Data stands in the cycle after the taking edge
    task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        sfrReq = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(negedge clock);
        d = sfrRdata;
        sfrReq = '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
    endtask
endmodule

// >>> tb/tb_aux_irq_and_breakpoint_unit.sv
/*
 * Self-checking bench for the aux interrupt and breakpoint unit.
 * Assumes the core model drives the register bus; other inputs here.
 */
`timescale 1ns/10ps

`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_fail++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end

module tb_aux_irq_and_breakpoint_unit;
    logic clock, reset_n, analogSupplyLow, digitalSupplyLow, brkSlotSelect, dataAddrValid, progAddrValid;
    logic sfrHit, auxIrqReq, convHoldOff, brkHitAny;
    logic [15:0] dataAddr, progAddr, auxIrqVector;
    logic [7:0] sfrRdata, rv;
    logic [6:0] stdIrqReq;
    logic [3:0] auxPendingIndex;
    aib_pkg::aib_sfr_req_t sfrReq;
    aib_pkg::aib_aux_evt_t auxEvt;
    aib_pkg::aib_std_src_t stdSrc;
    logic [7:0]            ieVals [6] = '{8'h00, 8'h7F, 8'h80, 8'hAA, 8'hD5, 8'hFF};
    int                    n_fail = 0;
    int                    num_checks = 0;
    int                    cycles = 0;

    aib_top #(.NUM_SLOTS(2), .SEL_W(1)) dut (.*);

    aib_core_model core (.clock(clock), .sfrReq(sfrReq), .sfrRdata(sfrRdata));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        core.sfr_wr(a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] ex);
        logic [7:0] v;
        core.sfr_rd(a, v);
        `CHK("rdata", ex, v)
        `CHK("sfrHit", (a >= 8'hA5 && a <= 8'hAB), sfrHit)
    endtask

    task automatic pulse(input logic [9:0] m);
        @(negedge clock);
        auxEvt = aib_pkg::aib_aux_evt_t'(m);
        @(negedge clock);
        auxEvt = '0;
    endtask

    task automatic access(input logic isProg, input logic [15:0] a);
        @(negedge clock);
        progAddr = a;
        dataAddr = a;
        progAddrValid = isProg;
        dataAddrValid = !isProg;
        @(negedge clock);
        progAddrValid = 1'b0;
        dataAddrValid = 1'b0;
        progAddr = ~a;
        dataAddr = ~a;
        idle(3);
    endtask

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_fail++;
            $display("timeout");
            report_and_stop();
        end
    end

    initial
    begin
        reset_n = 1'b0;
        auxEvt = '0;
        analogSupplyLow = 1'b0;
        digitalSupplyLow = 1'b0;
        stdSrc = '0;
        brkSlotSelect = 1'b0;
        dataAddr = 16'h0000;
        dataAddrValid = 1'b0;
        progAddr = 16'h0000;
        progAddrValid = 1'b0;
        repeat (8) @(negedge clock);
        reset_n = 1'b1;
        for (int a = 'hA5; a <= 'hAB; a++)
            rdc(8'(a), 8'h00);
        rdc(8'hB0, 8'h00);
        `CHK("auxIrqVector", 16'h0033, auxIrqVector)
        $display("test reset done");
        wr(8'hA6, 8'hFF);
        for (int k = 2; k < 8; k++)
        begin
            pulse(10'h001 << (k + 2));
            idle(3);
            rdc(8'hA5, 8'(k + 1));
            rdc(8'hA7, 8'h01 << k);
            `CHK("auxPendingIndex", 4'(k + 1), auxPendingIndex)
            `CHK("auxIrqReq", 1'b1, auxIrqReq)
            if (k == 5) `CHK("convHoldOff", 1'b1, convHoldOff)
            wr(8'hA6, 8'h00);
            rdc(8'hA7, 8'h00);
            rdc(8'hA6, 8'h01 << k);
            wr(8'hA6, 8'hFF);
            if (k == 3) wr(8'h9B, 8'h5A);
            else if (k == 2) core.sfr_rd(8'h9B, rv);
            else pulse(10'h001 << (k - 4));
            idle(3);
            rdc(8'hA7, 8'h00);
            `CHK("auxIrqReq", 1'b0, auxIrqReq)
            if (k == 5) `CHK("convHoldOff", 1'b0, convHoldOff)
        end
        $display("test aux sources done");
        pulse(10'h3F0);
        idle(3);
        rdc(8'hA7, 8'hFC);
        `CHK("auxPendingIndex", 4'h3, auxPendingIndex)
        core.sfr_rd(8'h9B, rv);
        idle(3);
        `CHK("auxPendingIndex", 4'h4, auxPendingIndex)
        wr(8'h9B, 8'h00);
        pulse(10'h00F);
        idle(3);
        rdc(8'hA7, 8'h00);
        $display("test priority done");
        wr(8'hA6, 8'hFE);
        analogSupplyLow = 1'b1;
        idle(3);
        rdc(8'hA7, 8'h02);
        rdc(8'hA7, 8'h02);
        wr(8'hA6, 8'hFF);
        digitalSupplyLow = 1'b1;
        idle(3);
        rdc(8'hA7, 8'h03);
        `CHK("auxPendingIndex", 4'h1, auxPendingIndex)
        analogSupplyLow = 1'b0;
        digitalSupplyLow = 1'b0;
        idle(3);
        rdc(8'hA7, 8'h00);
        $display("test supply levels done");
        stdSrc = '1;
        foreach (ieVals[i])
        begin
            wr(8'hA8, ieVals[i]);
            idle(2);
            rdc(8'hA8, ieVals[i]);
            `CHK("stdIrqReq", ieVals[i][7] ? ieVals[i][6:0] : 7'h00, stdIrqReq)
        end
        for (int i = 0; i < 9; i++)
        begin
            stdSrc = aib_pkg::aib_std_src_t'(9'h001 << i);
            idle(2);
            `CHK("stdIrqReq", 7'h01 << ((i < 5) ? i : (i == 8) ? 6 : i - 1), stdIrqReq)
        end
        stdSrc = '0;
        $display("test enables done");
        wr(8'hAA, 8'h34);
        wr(8'hAB, 8'h12);
        wr(8'hA9, 8'h01);
        rdc(8'hA9, 8'h01);
        rdc(8'hAA, 8'h34);
        rdc(8'hAB, 8'h12);
        access(1'b1, 16'h1234);
        access(1'b0, 16'h1235);
        access(1'b0, 16'h3412);
        `CHK("brkHitAny", 1'b0, brkHitAny)
        access(1'b0, 16'h1234);
        `CHK("brkHitAny", 1'b1, brkHitAny)
        rdc(8'hA9, 8'h81);
        rdc(8'hA7, 8'h01);
        wr(8'hA9, 8'h00);
        rdc(8'hA9, 8'h80);
        wr(8'hA9, 8'h80);
        idle(2);
        `CHK("brkHitAny", 1'b0, brkHitAny)
        rdc(8'hA7, 8'h00);
        wr(8'hA9, 8'h03);
        access(1'b0, 16'h1234);
        `CHK("brkHitAny", 1'b0, brkHitAny)
        access(1'b1, 16'h1234);
        `CHK("brkHitAny", 1'b1, brkHitAny)
        brkSlotSelect = 1'b1;
        wr(8'hAA, 8'h78);
        wr(8'hAB, 8'h56);
        wr(8'hA9, 8'h01);
        access(1'b0, 16'h5678);
        brkSlotSelect = 1'b0;
        wr(8'hA9, 8'h80);
        idle(2);
        `CHK("brkHitAny", 1'b1, brkHitAny)
        brkSlotSelect = 1'b1;
        wr(8'hA9, 8'h80);
        idle(2);
        `CHK("brkHitAny", 1'b0, brkHitAny)
        access(1'b0, 16'h5678);
        `CHK("brkHitAny", 1'b0, brkHitAny)
        $display("test breakpoints done");
        report_and_stop();
    end
endmodule

bind aib_top aib_top_props #(.NUM_SLOTS(NUM_SLOTS), .SEL_W(SEL_W)) u_props (.*);
